/* File: scc_pkg.sv */
// package: register map, field layout, reset values and timing for the clock source control
package scc_pkg;

  localparam int unsigned ADDR_W = 4;

  localparam logic [3:0] OFF_IRQ_EN   = 4'h0;
  localparam logic [3:0] OFF_SYS_SEL  = 4'h2;
  localparam logic [3:0] OFF_OSC_CTL  = 4'h4;
  localparam logic [3:0] OFF_TRIM_CTL = 4'h6;
  localparam logic [3:0] OFF_SLOW_CTL = 4'h8;
  localparam logic [3:0] OFF_FLAGS    = 4'hA;
  localparam logic [3:0] OFF_PROT     = 4'hC;

  localparam logic [15:0] PROT_KEY = 16'h0096;

  // system_clock_select fields
  localparam int unsigned BIT_WAKE_EN   = 15;
  localparam int unsigned POS_WAKE_DIV  = 12;
  localparam int unsigned POS_WAKE_SRC  = 8;
  localparam int unsigned POS_SYS_DIV   = 4;
  localparam int unsigned POS_SYS_SRC   = 0;
  // oscillation_control fields
  localparam int unsigned POS_SLEEP_STOP = 8;
  localparam int unsigned POS_SRC_EN     = 0;
  localparam logic [3:0]  SLEEP_STOP_RST = 4'hF;
  localparam logic [3:0]  SRC_EN_RST     = 4'h1;
  // rc_trim_control
  localparam int unsigned BIT_TRIM_START = 4;
  // slow_crystal_control
  localparam int unsigned BIT_RESTART_EN = 14;
  localparam int unsigned BIT_DETECT_EN  = 13;
  localparam int unsigned BIT_BOOST_EN   = 12;
  localparam int unsigned POS_GATE_CAP   = 8;
  localparam int unsigned POS_INV_BOOST  = 6;
  localparam int unsigned POS_INV_NORM   = 4;
  localparam int unsigned POS_SLOW_WAIT  = 0;
  localparam logic [15:0] SLOW_CTL_RST   = 16'h5092;
  localparam logic [15:0] SLOW_CTL_MASK  = 16'h77F3;
  // flag register bits
  localparam int unsigned BIT_TRIM_DONE  = 4;
  localparam int unsigned BIT_SLOW_STBL  = 1;

  // stabilization waits in slow crystal clocks
  localparam int unsigned SLOW_WAIT_3 = 65536;
  localparam int unsigned SLOW_WAIT_2 = 16384;
  localparam int unsigned SLOW_WAIT_1 = 4096;
  localparam int unsigned WAIT_CNT_W  = 17;

  typedef enum logic [1:0] {
    SRC_RC   = 2'h0,
    SRC_SLOW = 2'h1,
    SRC_FAST = 2'h2,
    SRC_EXT  = 2'h3
  } scc_src_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [15:0]       wdata;
    logic              wr;
    logic              rd;
  } scc_bus_req_t;

  // true when source/divider pair is a legal combination
  function automatic logic scc_div_legal(input logic [1:0] src, input logic [1:0] div);
    case (src)
      SRC_RC:   scc_div_legal = 1'b1;
      SRC_FAST: scc_div_legal = 1'b1;
      SRC_SLOW: scc_div_legal = (div <= 2'h1);
      default:  scc_div_legal = (div == 2'h0);
    endcase
  endfunction

  // divide exponent (log2 ratio) of a legal pair
  function automatic logic [3:0] scc_div_exp(input logic [1:0] src, input logic [1:0] div);
    if (src == SRC_FAST && div >= 2'h2) begin
      scc_div_exp = {2'b00, div} + 4'h1;
    end else begin
      scc_div_exp = {2'b00, div};
    end
  endfunction

endpackage

/* File: scc_clk_div.sv */
// power-of-two divider giving a one-cycle system tick
`timescale 1ns/100ps
`default_nettype none
module scc_clk_div #(
  parameter int unsigned CNT_W = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [3:0]       div_exp,
  output var  logic             tick
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] limit;
  logic             wrap;

  assign limit    = CNT_W'((16'h1 << div_exp) - 16'h1);
  assign wrap     = (cnt_reg >= limit);
  assign cnt_next = wrap ? '0 : cnt_reg + 1'b1;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick    <= wrap;
    end
  end
endmodule // scc_clk_div
`default_nettype wire

/* File: scc_stab_wait.sv */
// slow crystal stabilization wait counter
`timescale 1ns/100ps
`default_nettype none
module scc_stab_wait
  import scc_pkg::*;
#(
  parameter int unsigned WAIT_3 = SLOW_WAIT_3,
  parameter int unsigned WAIT_2 = SLOW_WAIT_2,
  parameter int unsigned WAIT_1 = SLOW_WAIT_1
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       run,
  input  wire logic       slow_tick,
  input  wire logic [1:0] sel,
  output var  logic       done
);
  logic [WAIT_CNT_W-1:0] cnt_reg;
  logic [WAIT_CNT_W-1:0] target;
  logic                  hit;

  assign target = (sel == 2'h3) ? WAIT_CNT_W'(WAIT_3) :
                  (sel == 2'h1) ? WAIT_CNT_W'(WAIT_1) : WAIT_CNT_W'(WAIT_2);
  assign hit    = run && slow_tick && !done && (cnt_reg + 1'b1 >= target);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
      done    <= 1'b0;
    end else if (!run) begin
      cnt_reg <= '0;
      done    <= 1'b0;
    end else if (hit) begin
      done    <= 1'b1;
    end else if (slow_tick && !done) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule // scc_stab_wait
`default_nettype wire

/* File: scc_top.sv */
// clock source control: selection, wake switching, sleep control, rc trim sequencing
// Functional notes
// - bit 0 of irq enable register gates mode-done flag onto interrupt request
// - wake switching on: wake source/divider copied to system fields at wake-up
// - wake switching off: system fields untouched, wake fields have no effect
// - after wake switch, enables cleared except selected source and sleep-kept ones
// - source codes 0 rc, 1 slow crystal, 2 fast oscillator, 3 external input
// - divider per source: rc 1..1/8, fast 1..1/16, slow 1/1-1/2, ext 1/1
// - wake divider uses the same per-source encoding when loaded
// - selecting a stopped source as system clock starts it automatically; a select write in a SLEEP_ENTER cycle switches without starting it
// - bits 11..8 stop each source in sleep when 1; reset to 1
// - bits 3..0 enable each source; only rc enable resets to 1
// - trim start bit starts/stops trimming, reads 1 while running, self-clears
// - trimming runs only while slow crystal runs; software checks stable flag
// - slow control bit 14 enables restart on stop detection; resets to 1
// - trim done flag bit 4 set on completion, cleared by writing 1
// - slow stable flag set after stabilization wait, cleared by writing 1
// - wait field 3:65536, 2:16384, 1:4096 clocks, 0 reserved, reset 2
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module scc_top (
  input  wire logic                  CLK,
  input  wire logic                  RST_B,
  input  wire scc_pkg::scc_bus_req_t BUS_REQ,
  output var  logic [15:0]           BUS_RDATA,
  input  wire logic                  SLEEP_ENTER,
  input  wire logic                  WAKE_UP,
  input  wire logic                  MODE_DONE_FLAG,
  input  wire logic                  SLOW_TICK,
  input  wire logic                  SLOW_STOP_DETECT,
  input  wire logic                  TRIM_FINISHED,
  output var  logic                  MODE_DONE_IRQ,
  output var  logic [3:0]            SOURCE_RUN,
  output var  logic [1:0]            SYSTEM_SOURCE,
  output var  logic [3:0]            SYSTEM_DIV_EXP,
  output var  logic                  SYSTEM_TICK,
  output var  logic                  TRIM_RUN,
  output var  logic                  SLOW_RESTART,
  output var  logic                  STOP_DETECT_EN,
  output var  logic [15:0]           SLOW_CTL
);
  import scc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic        irq_en_reg;
  logic        wake_en_reg;
  logic [1:0]  wake_div_reg;
  logic [1:0]  wake_src_reg;
  logic [1:0]  sys_div_reg;
  logic [1:0]  sys_src_reg;
  logic [3:0]  sleep_stop_reg;
  logic [3:0]  src_en_reg;
  logic [3:0]  src_en_next;
  logic        trim_reg;
  logic        trim_next;
  logic [15:0] slow_ctl_reg;
  logic        trim_done_reg;
  logic        slow_stbl_reg;
  logic        unlock_reg;
  logic        asleep_reg;
  logic [3:0]  kept_reg;
  logic [15:0] rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire wr_any     = BUS_REQ.wr;
  wire [15:0] wd  = BUS_REQ.wdata;
  wire wr_irq     = wr_any && BUS_REQ.addr == OFF_IRQ_EN;
  wire wr_sel     = wr_any && BUS_REQ.addr == OFF_SYS_SEL && unlock_reg;
  wire wr_osc     = wr_any && BUS_REQ.addr == OFF_OSC_CTL;
  wire wr_trim    = wr_any && BUS_REQ.addr == OFF_TRIM_CTL && unlock_reg;
  wire wr_slow    = wr_any && BUS_REQ.addr == OFF_SLOW_CTL && unlock_reg;
  wire wr_flags   = wr_any && BUS_REQ.addr == OFF_FLAGS;
  wire wr_prot    = wr_any && BUS_REQ.addr == OFF_PROT;

  // legal writes only; reserved pairs keep the previous selection
  wire [1:0] new_src   = wd[POS_SYS_SRC +: 2];
  wire [1:0] new_div   = wd[POS_SYS_DIV +: 2];
  wire       sel_legal = scc_div_legal(new_src, new_div);
  wire       wake_ok   = scc_div_legal(wake_src_reg, wake_div_reg);
  wire       wake_load = WAKE_UP && asleep_reg && wake_en_reg && wake_ok;

  ////////////////////////////////////////////////////////////////////////////
  // source enables, sleep stop and wake pruning
  logic [3:0] sel_onehot;
  logic [3:0] wake_onehot;
  assign sel_onehot  = 4'h1 << (wr_sel && sel_legal ? new_src : sys_src_reg);
  assign wake_onehot = 4'h1 << wake_src_reg;

  always_comb begin
    src_en_next = src_en_reg;
    if (wr_osc) begin
      src_en_next = wd[POS_SRC_EN +: 4];
    end
    if (wr_sel && sel_legal) begin
      src_en_next = src_en_next | sel_onehot;
    end
    if (SLEEP_ENTER) begin
      src_en_next = src_en_reg;
    end
    if (wake_load) begin
      src_en_next = wake_onehot | (kept_reg & src_en_reg);
    end
  end

  // running set: in sleep a source runs only if its stop bit was clear
  assign SOURCE_RUN = asleep_reg ? (src_en_reg & ~sleep_stop_reg) : src_en_reg;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      src_en_reg     <= SRC_EN_RST;
      sleep_stop_reg <= SLEEP_STOP_RST;
      asleep_reg     <= 1'b0;
      kept_reg       <= 4'h0;
    end else begin
      src_en_reg <= src_en_next;
      if (wr_osc) begin
        sleep_stop_reg <= wd[POS_SLEEP_STOP +: 4];
      end
      if (SLEEP_ENTER) begin
        asleep_reg <= 1'b1;
        kept_reg   <= src_en_reg & ~sleep_stop_reg;
      end else if (WAKE_UP) begin
        asleep_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system clock select
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wake_en_reg  <= 1'b0;
      wake_div_reg <= 2'h0;
      wake_src_reg <= 2'h0;
      sys_div_reg  <= 2'h0;
      sys_src_reg  <= SRC_RC;
    end else begin
      if (wr_sel) begin
        wake_en_reg  <= wd[BIT_WAKE_EN];
        wake_div_reg <= wd[POS_WAKE_DIV +: 2];
        wake_src_reg <= wd[POS_WAKE_SRC +: 2];
      end
      if (wake_load) begin
        sys_src_reg <= wake_src_reg;
        sys_div_reg <= wake_div_reg;
      end else if (wr_sel && sel_legal) begin
        sys_src_reg <= new_src;
        sys_div_reg <= new_div;
      end
    end
  end

  assign SYSTEM_SOURCE  = sys_src_reg;
  assign SYSTEM_DIV_EXP = scc_div_exp(sys_src_reg, sys_div_reg);

  scc_clk_div #(
    .CNT_W (4)
  ) u_div (
    .clk     (CLK),
    .rst_b   (RST_B),
    .div_exp (SYSTEM_DIV_EXP),
    .tick    (SYSTEM_TICK)
  );

  ////////////////////////////////////////////////////////////////////////////
  // slow crystal control and stabilization
  wire slow_runs = SOURCE_RUN[SRC_SLOW];
  logic stab_done;
  logic stab_done_d;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      slow_ctl_reg <= SLOW_CTL_RST;
      stab_done_d  <= 1'b0;
    end else begin
      if (wr_slow) begin
        slow_ctl_reg <= wd & SLOW_CTL_MASK;
      end
      stab_done_d <= stab_done;
    end
  end

  assign SLOW_CTL       = slow_ctl_reg;
  assign STOP_DETECT_EN = slow_ctl_reg[BIT_DETECT_EN];
  assign SLOW_RESTART   = SLOW_STOP_DETECT && slow_ctl_reg[BIT_RESTART_EN] && slow_runs;

  scc_stab_wait u_wait (
    .clk       (CLK),
    .rst_b     (RST_B),
    .run       (slow_runs && !SLOW_STOP_DETECT),
    .slow_tick (SLOW_TICK),
    .sel       (slow_ctl_reg[POS_SLOW_WAIT +: 2]),
    .done      (stab_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // rc auto-trim and flags
  wire trim_abort = !slow_runs;
  always_comb begin
    trim_next = trim_reg;
    if (wr_trim) begin
      trim_next = wd[BIT_TRIM_START] && slow_runs;
    end
    if (trim_reg && (TRIM_FINISHED || trim_abort)) begin
      trim_next = 1'b0;
    end
  end
  assign TRIM_RUN = trim_reg;

  wire trim_done_set = trim_reg && TRIM_FINISHED;
  wire stbl_set      = stab_done && !stab_done_d;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      trim_reg      <= 1'b0;
      trim_done_reg <= 1'b0;
      slow_stbl_reg <= 1'b0;
      irq_en_reg    <= 1'b0;
      unlock_reg    <= 1'b0;
    end else begin
      trim_reg <= trim_next;
      if (trim_done_set) begin
        trim_done_reg <= 1'b1;
      end else if (wr_flags && wd[BIT_TRIM_DONE]) begin
        trim_done_reg <= 1'b0;
      end
      if (stbl_set) begin
        slow_stbl_reg <= 1'b1;
      end else if (wr_flags && wd[BIT_SLOW_STBL]) begin
        slow_stbl_reg <= 1'b0;
      end
      if (wr_irq) begin
        irq_en_reg <= wd[0];
      end
      if (wr_prot) begin
        unlock_reg <= (wd == PROT_KEY);
      end
    end
  end

  assign MODE_DONE_IRQ = MODE_DONE_FLAG && irq_en_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read back, reserved bits zero
  logic [15:0] rd_mux;
  always_comb begin
    case (BUS_REQ.addr)
      OFF_IRQ_EN:   rd_mux = {15'h0000, irq_en_reg};
      OFF_SYS_SEL:  rd_mux = {wake_en_reg, 1'b0, wake_div_reg, 2'b00, wake_src_reg,
                              2'b00, sys_div_reg, 2'b00, sys_src_reg};
      OFF_OSC_CTL:  rd_mux = {4'h0, sleep_stop_reg, 4'h0, src_en_reg};
      OFF_TRIM_CTL: rd_mux = {11'h000, trim_reg, 4'h0};
      OFF_SLOW_CTL: rd_mux = slow_ctl_reg;
      OFF_FLAGS:    rd_mux = {11'h000, trim_done_reg, 2'b00, slow_stbl_reg, 1'b0};
      OFF_PROT:     rd_mux = {15'h0000, unlock_reg};
      default:      rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= BUS_REQ.rd ? rd_mux : 16'h0000;
    end
  end
  assign BUS_RDATA = rdata_reg;

endmodule // scc_top
`default_nettype wire

/* File: scc_top_props.sv */
// checker: port-level properties of the clock source control
`timescale 1ns/100ps
`default_nettype none
module scc_top_props (
  input wire logic                  CLK,
  input wire logic                  RST_B,
  input wire scc_pkg::scc_bus_req_t BUS_REQ,
  input wire logic [15:0]           BUS_RDATA,
  input wire logic                  SLEEP_ENTER,
  input wire logic                  MODE_DONE_IRQ,
  input wire logic                  SLOW_STOP_DETECT,
  input wire logic                  TRIM_FINISHED,
  input wire logic [3:0]            SOURCE_RUN,
  input wire logic [1:0]            SYSTEM_SOURCE,
  input wire logic [3:0]            SYSTEM_DIV_EXP,
  input wire logic                  SYSTEM_TICK,
  input wire logic                  TRIM_RUN,
  input wire logic                  SLOW_RESTART,
  input wire logic [15:0]           SLOW_CTL
);
  import scc_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  irq_gate_a: assert property (
    BUS_REQ.wr && BUS_REQ.addr == OFF_IRQ_EN && !BUS_REQ.wdata[0] |=> !MODE_DONE_IRQ)
    else $error("irq stays up after enable cleared");
  unmapped_zero_a: assert property (
    BUS_REQ.rd && BUS_REQ.addr == 4'hE |=> BUS_RDATA == 16'h0000)
    else $error("unmapped read not zero");
  ctl_reserved_a: assert property ((SLOW_CTL & ~SLOW_CTL_MASK) == 16'h0000)
    else $error("reserved slow control bit set");
  restart_a: assert property (
    SLOW_RESTART == (SLOW_STOP_DETECT & SLOW_CTL[BIT_RESTART_EN] & SOURCE_RUN[1]))
    else $error("restart request wrong");
  div_pair_a: assert property (
    (SYSTEM_SOURCE == SRC_RC && SYSTEM_DIV_EXP <= 4'h3) ||
    (SYSTEM_SOURCE == SRC_SLOW && SYSTEM_DIV_EXP <= 4'h1) ||
    (SYSTEM_SOURCE == SRC_FAST && SYSTEM_DIV_EXP inside {4'h0, 4'h1, 4'h3, 4'h4}) ||
    (SYSTEM_SOURCE == SRC_EXT && SYSTEM_DIV_EXP == 4'h0))
    else $error("illegal source and divider pair");
  tick_gap_a: assert property (
    SYSTEM_TICK && SYSTEM_DIV_EXP == 4'h1 ##1 SYSTEM_DIV_EXP == 4'h1 |-> !SYSTEM_TICK)
    else $error("tick too early for half rate");
  trim_done_a: assert property (TRIM_RUN && TRIM_FINISHED |=> !TRIM_RUN)
    else $error("trim bit not cleared on finish");
  trim_slow_a: assert property (!SOURCE_RUN[1] |=> !TRIM_RUN)
    else $error("trim runs without slow crystal");
  sleep_freeze_a: assert property (
    SLEEP_ENTER |=> (SOURCE_RUN & ~$past(SOURCE_RUN)) == 4'h0)
    else $error("source started on sleep entry");
endmodule // scc_top_props

bind scc_top scc_top_props i_props (.CLK(CLK), .RST_B(RST_B), .BUS_REQ(BUS_REQ),
  .BUS_RDATA(BUS_RDATA), .SLEEP_ENTER(SLEEP_ENTER), .MODE_DONE_IRQ(MODE_DONE_IRQ),
  .SLOW_STOP_DETECT(SLOW_STOP_DETECT), .TRIM_FINISHED(TRIM_FINISHED),
  .SOURCE_RUN(SOURCE_RUN), .SYSTEM_SOURCE(SYSTEM_SOURCE), .SYSTEM_DIV_EXP(SYSTEM_DIV_EXP),
  .SYSTEM_TICK(SYSTEM_TICK), .TRIM_RUN(TRIM_RUN), .SLOW_RESTART(SLOW_RESTART),
  .SLOW_CTL(SLOW_CTL));
`default_nettype wire

/* File: tb.sv */
// testbench: registers, selection, wake, trim and restart of the clock source control
`timescale 1ns/100ps
`default_nettype none
module tb;
  import scc_pkg::*;
  typedef struct packed {
    logic        wr;
    logic [3:0]  addr;
    logic [15:0] data;
    logic [15:0] exp;
  } scc_row_t;
  logic         clk, rst_b, sleep_enter, wake_up, mode_flag, stop_det, trim_fin;
  logic         irq, trim_run, restart, det_en;
  logic         slow_tick = 1'b0;
  logic [3:0]   run, div_exp;
  logic [1:0]   sys_src;
  logic [15:0]  rdata, v;
  scc_bus_req_t req;
  scc_row_t     rows [16];
  logic [1:0]   dv [4] = '{2'h3, 2'h1, 2'h3, 2'h0};
  logic [3:0]   ex [4] = '{4'h3, 4'h1, 4'h4, 4'h0};
  int           bad_count, checked;

  scc_top i_scc_top (.CLK(clk), .RST_B(rst_b), .BUS_REQ(req), .BUS_RDATA(rdata),
    .SLEEP_ENTER(sleep_enter), .WAKE_UP(wake_up), .MODE_DONE_FLAG(mode_flag),
    .SLOW_TICK(slow_tick), .SLOW_STOP_DETECT(stop_det), .TRIM_FINISHED(trim_fin),
    .MODE_DONE_IRQ(irq), .SOURCE_RUN(run), .SYSTEM_SOURCE(sys_src),
    .SYSTEM_DIV_EXP(div_exp), .SYSTEM_TICK(), .TRIM_RUN(trim_run),
    .SLOW_RESTART(restart), .STOP_DETECT_EN(det_en), .SLOW_CTL());

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // slow crystal tick at half the system rate
  always @(posedge clk) begin
    slow_tick <= ~slow_tick;
  end

  task automatic stop_test;
    if (bad_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
    #1;
  endtask

  task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    #1 d = rdata;
  endtask

  task automatic run_rows(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      if (rows[i].wr) bus_wr(rows[i].addr, rows[i].data);
      bus_rd(rows[i].addr, v);
      chk($sformatf("reg %h", rows[i].addr), v, rows[i].exp);
    end
  endtask

  task automatic sleep_wake;
    @(posedge clk) sleep_enter <= 1'b1;
    @(posedge clk) sleep_enter <= 1'b0;
    settle(3);
    @(posedge clk) wake_up <= 1'b1;
    @(posedge clk) wake_up <= 1'b0;
    #1;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    stop_test;
  end

  initial begin
    rst_b = 1'b0; req = '0; sleep_enter = 1'b0; wake_up = 1'b0; mode_flag = 1'b0;
    stop_det = 1'b0; trim_fin = 1'b0; bad_count = 0; checked = 0;
    rows = '{'{1'b0, 4'h0, 16'h0000, 16'h0000}, '{1'b0, 4'h2, 16'h0000, 16'h0000},
      '{1'b0, 4'h4, 16'h0000, 16'h0F01}, '{1'b0, 4'h6, 16'h0000, 16'h0000},
      '{1'b0, 4'h8, 16'h0000, 16'h5092}, '{1'b0, 4'hA, 16'h0000, 16'h0000},
      '{1'b0, 4'hE, 16'h0000, 16'h0000}, '{1'b1, 4'h2, 16'h0013, 16'h0000},
      '{1'b1, 4'h4, 16'hFFFF, 16'h0F0F}, '{1'b1, 4'hC, 16'h0096, 16'h0001},
      '{1'b1, 4'h2, 16'h8301, 16'h8301}, '{1'b1, 4'h2, 16'h0033, 16'h0001},
      '{1'b1, 4'h0, 16'hFFFF, 16'h0001}, '{1'b1, 4'h8, 16'hFFFF, 16'h77F3},
      '{1'b1, 4'h8, 16'h5092, 16'h5092}, '{1'b1, 4'hC, 16'h1234, 16'h0000}};
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    run_rows(0, 15);
    @(posedge clk) mode_flag <= 1'b1;
    settle(1);
    chk("irq on", 16'(irq), 16'h0001);
    bus_wr(OFF_IRQ_EN, 16'h0000);
    chk("irq off", 16'(irq), 16'h0000);
    bus_wr(OFF_PROT, PROT_KEY);
    bus_wr(OFF_OSC_CTL, 16'h0F01);
    for (int s = 0; s < 4; s++) begin
      bus_wr(OFF_SYS_SEL, {10'h000, dv[s], 2'b00, 2'(s)});
      settle(8);
      chk("source", 16'(sys_src), 16'(s));
      chk("divide", 16'(div_exp), 16'(ex[s]));
      chk("autostart", 16'(run[s]), 16'h0001);
    end
    bus_wr(OFF_SYS_SEL, 16'hA200);
    bus_wr(OFF_OSC_CTL, 16'h0D07);
    @(posedge clk) sleep_enter <= 1'b1;
    @(posedge clk) sleep_enter <= 1'b0;
    #1 chk("sleep run", 16'(run), 16'h0002);
    settle(3);
    @(posedge clk) wake_up <= 1'b1;
    @(posedge clk) wake_up <= 1'b0;
    #1 chk("wake source", 16'(sys_src), 16'h0002);
    chk("wake divide", 16'(div_exp), 16'h0003);
    chk("wake run", 16'(run), 16'h0006);
    bus_rd(OFF_SYS_SEL, v);
    chk("wake select", v, 16'hA222);
    bus_rd(OFF_OSC_CTL, v);
    chk("wake enables", v, 16'h0D06);
    bus_wr(OFF_SYS_SEL, 16'h2200);
    sleep_wake;
    chk("kept source", 16'(sys_src), 16'h0000);
    chk("kept divide", 16'(div_exp), 16'h0000);
    bus_wr(OFF_OSC_CTL, 16'h0F01);
    bus_wr(OFF_FLAGS, 16'h0012);
    bus_wr(OFF_SLOW_CTL, 16'h5091);
    bus_wr(OFF_OSC_CTL, 16'h0F03);
    settle(8192 - 64);
    bus_rd(OFF_FLAGS, v);
    chk("stable early", v & 16'h0002, 16'h0000);
    settle(128);
    bus_rd(OFF_FLAGS, v);
    chk("stable set", v & 16'h0002, 16'h0002);
    bus_wr(OFF_FLAGS, 16'h0002);
    bus_rd(OFF_FLAGS, v);
    chk("stable clear", v & 16'h0002, 16'h0000);
    bus_wr(OFF_SYS_SEL, 16'h0001);
    bus_wr(OFF_TRIM_CTL, 16'h0010);
    chk("trim run", 16'(trim_run), 16'h0001);
    bus_rd(OFF_TRIM_CTL, v);
    chk("trim read", v, 16'h0010);
    @(posedge clk) trim_fin <= 1'b1;
    @(posedge clk) trim_fin <= 1'b0;
    bus_rd(OFF_TRIM_CTL, v);
    chk("trim end", v, 16'h0000);
    bus_rd(OFF_FLAGS, v);
    chk("trim flag", v & 16'h0010, 16'h0010);
    bus_wr(OFF_FLAGS, 16'h0010);
    bus_rd(OFF_FLAGS, v);
    chk("trim flag clear", v & 16'h0010, 16'h0000);
    @(posedge clk) stop_det <= 1'b1;
    settle(1);
    chk("restart on", 16'(restart), 16'h0001);
    bus_wr(OFF_SLOW_CTL, 16'h3092);
    chk("restart off", 16'(restart), 16'h0000);
    chk("detect enable", 16'(det_en), 16'h0001);
    bus_wr(OFF_OSC_CTL, 16'h0F01);
    bus_wr(OFF_TRIM_CTL, 16'h0010);
    settle(1);
    chk("trim no slow", 16'(trim_run), 16'h0000);
    @(posedge clk) rst_b <= 1'b0;
    settle(2);
    @(posedge clk) rst_b <= 1'b1;
    run_rows(0, 6);
    chk("irq reset", 16'(irq), 16'h0000);
    stop_test;
  end
endmodule // tb
`default_nettype wire
